// ---- common/ocd_defs.vh ----
`ifndef OCD_DEFS_VH
`define OCD_DEFS_VH

// Register indices, byte address is four times the index
`define OCD_IDX_CTRL      8'h27
`define OCD_IDX_SUPPLY    8'h28
`define OCD_IDX_FRAC_UP   8'h29
`define OCD_IDX_FRAC_LO   8'h2a
`define OCD_IDX_STATUS    8'h3f

// Reset values
`define OCD_RST_CTRL      16'h0679
`define OCD_RST_SUPPLY    16'h0008
`define OCD_RST_FRAC_UP   16'h8000
`define OCD_RST_FRAC_LO   16'h0000

// Control register fields, then the supply register flag bit and the lower fraction width
`define OCD_B_DELAY       15
`define OCD_B_BYPASS      14
`define OCD_B_FRST        13
`define OCD_B_SRC         12
`define OCD_F_DIV_HI      11
`define OCD_F_DIV_LO      9
`define OCD_B_PROFILE     8
`define OCD_F_DEPTH_HI    7
`define OCD_F_DEPTH_LO    6
`define OCD_F_PER_HI      5
`define OCD_F_PER_LO      4
`define OCD_B_SPEN        3
`define OCD_B_SAFE        0
`define OCD_B_LOWSUP      3
`define OCD_LO_W          9

// Modulation period in counter cycles
`define OCD_PER_0         10'h0f0
`define OCD_PER_1         10'h190
`define OCD_PER_2         10'h208
`define OCD_PER_3         10'h22c

// Applied configuration: control, upper, lower
`define OCD_CFG_W         41
`define OCD_CFG_RST       {`OCD_RST_CTRL, `OCD_RST_FRAC_UP, 9'h000}

`endif

// ---- design/ocd_safe_switch.v ----
`timescale 1ns/1ps
`include "ocd_defs.vh"
module ocd_safe_switch (
  input  wire                  core_clk,
  input  wire                  rst_n,
  input  wire [`OCD_CFG_W-1:0] newCfg,
  input  wire                  safeEn,
  input  wire                  boundary,
  output reg  [`OCD_CFG_W-1:0] appliedCfg_ff,
  output wire                  pending
);
  reg [`OCD_CFG_W-1:0] nxt_appliedCfg;

  assign pending = (newCfg != appliedCfg_ff);

  always @* begin
    nxt_appliedCfg = appliedCfg_ff;
    if (!safeEn) begin
      nxt_appliedCfg = newCfg;
    end else if (boundary) begin
      nxt_appliedCfg = newCfg;
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      appliedCfg_ff <= `OCD_CFG_RST;
    end else begin
      appliedCfg_ff <= nxt_appliedCfg;
    end
  end
endmodule // ocd_safe_switch

// ---- design/ocd_spread_gen.v ----
`timescale 1ns/1ps
`include "ocd_defs.vh"
module ocd_spread_gen (
  input  wire       core_clk,
  input  wire       rst_n,
  input  wire       srcTick,
  input  wire       enable,
  input  wire [2:0] divide,
  input  wire [1:0] period,
  input  wire       downProfile,
  input  wire [1:0] depth,
  output reg  [9:0] modPhase_ff,
  output reg        modFalling_ff,
  output reg  [4:0] peakQuarter_ff,
  output reg        centreMode_ff
);
  reg [2:0] preCnt_ff;
  reg [2:0] nxt_preCnt;
  reg [9:0] nxt_modPhase;
  reg       nxt_modFalling;
  wire      modTick;
  wire [9:0] perLen;
  wire [9:0] halfLen;

  function [9:0] perDecode;
    input [1:0] code;
    begin
      case (code)
        2'h0: perDecode = `OCD_PER_0;
        2'h1: perDecode = `OCD_PER_1;
        2'h2: perDecode = `OCD_PER_2;
        default: perDecode = `OCD_PER_3;
      endcase
    end
  endfunction

  function [4:0] depthDecode;
    input [1:0] code;
    input       isDown;
    reg   [4:0] dn;
    begin
      case (code)
        2'h0: dn = 5'h02;
        2'h1: dn = 5'h04;
        2'h2: dn = 5'h08;
        default: dn = 5'h14;
      endcase
      depthDecode = isDown ? dn : {1'b0, dn[4:1]};
    end
  endfunction

  assign perLen  = perDecode(period);
  assign halfLen = {1'b0, perLen[9:1]};
  assign modTick = srcTick && (preCnt_ff == divide);

  always @* begin
    nxt_preCnt     = preCnt_ff;
    nxt_modPhase   = modPhase_ff;
    nxt_modFalling = modFalling_ff;
    if (!enable) begin
      nxt_preCnt     = 3'h0;
      nxt_modPhase   = 10'h000;
      nxt_modFalling = 1'b0;
    end else if (srcTick) begin
      nxt_preCnt = modTick ? 3'h0 : preCnt_ff + 3'h1;
      if (modTick) begin
        if (modPhase_ff >= perLen - 10'h001) begin
          nxt_modPhase   = 10'h000;
          nxt_modFalling = 1'b0;
        end else begin
          nxt_modPhase   = modPhase_ff + 10'h001;
          nxt_modFalling = (nxt_modPhase >= halfLen);
        end
      end
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      preCnt_ff      <= 3'h0;
      modPhase_ff    <= 10'h000;
      modFalling_ff  <= 1'b0;
      peakQuarter_ff <= 5'h00;
      centreMode_ff  <= 1'b1;
    end else begin
      preCnt_ff     <= nxt_preCnt;
      modPhase_ff   <= nxt_modPhase;
      modFalling_ff <= nxt_modFalling;
      centreMode_ff <= !downProfile;
      peakQuarter_ff <= enable ? depthDecode(depth, downProfile) : 5'h00;
    end
  end
endmodule // ocd_spread_gen

// ---- design/ocd_channel_config.v ----
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "ocd_defs.vh"
module ocd_channel_config (
  input  wire        core_clk,
  input  wire        rst_n,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output reg  [31:0] prdata_ff,
  output reg         pslverr_ff,
  input  wire        fracClkIn,
  input  wire        refClkIn,
  input  wire        chanClkIn,
  output reg         fracClkOut_ff,
  output reg         ch1_frac_delay_select,
  output reg         ch1_frac_bypass,
  output reg         ch1_frac_reset,
  output reg         ch1_spread_clock_source,
  output reg  [24:0] delayWord_ff,
  output reg         ch1_low_supply_flag,
  output wire [9:0]  modPhase,
  output wire        modFalling,
  output wire [4:0]  peakQuarter,
  output wire        centreMode,
  output reg         switchPending_ff
);
  localparam ST_IDLE = 2'b01;
  localparam ST_ACK  = 2'b10;

  reg  [1:0]  state_ff;
  reg  [1:0]  nxt_state;
  reg  [15:0] ctrl_ff;
  reg  [15:0] supply_ff;
  reg  [15:0] fracUp_ff;
  reg  [15:0] fracLo_ff;
  wire [2:0]  pinSync;
  reg  [24:0] acc_ff;
  reg  [24:0] nxt_acc;
  reg         nxt_fracOut;
  reg  [31:0] rdData;
  reg         decErr;
  wire [2:0]  pinIn;
  wire [2:0]  rise;
  wire [2:0]  fall;
  wire [7:0]  regIdx;
  wire        access;
  wire        wrEn;
  wire [`OCD_CFG_W-1:0] newCfg;
  wire [`OCD_CFG_W-1:0] appliedCfg;
  wire        pending;
  wire [15:0] actCtrl;
  wire [24:0] actFrac;
  wire        spreadTick;
  wire [25:0] accSum;

  function isMapped;
    input [7:0] idx;
    begin
      isMapped = (idx == `OCD_IDX_CTRL) || (idx == `OCD_IDX_SUPPLY) ||
                 (idx == `OCD_IDX_FRAC_UP) || (idx == `OCD_IDX_FRAC_LO) ||
                 (idx == `OCD_IDX_STATUS);
    end
  endfunction

  assign pinIn = {chanClkIn, refClkIn, fracClkIn};

  // Two-stage pin synchronisers
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_sync
      reg stage1_ff;
      reg stage2_ff;
      reg prev_ff;
      always @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
          stage1_ff <= 1'b0;
          stage2_ff <= 1'b0;
          prev_ff   <= 1'b0;
        end else begin
          stage1_ff <= pinIn[gi];
          stage2_ff <= stage1_ff;
          prev_ff   <= stage2_ff;
        end
      end
      assign pinSync[gi] = stage2_ff;
      assign rise[gi]    = stage2_ff && !prev_ff;
      assign fall[gi]    = !stage2_ff && prev_ff;
    end
  endgenerate

  // Bus decode
  assign regIdx = {2'b00, paddr[7:2]};
  assign access = psel && penable;
  assign pready = (state_ff == ST_ACK);
  assign wrEn   = access && pready && pwrite && isMapped(regIdx);

  always @* begin
    case (state_ff)
      ST_IDLE: nxt_state = access ? ST_ACK : ST_IDLE;
      ST_ACK:  nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always @* begin
    rdData = 32'h00000000;
    decErr = 1'b0;
    case (regIdx)
      `OCD_IDX_CTRL:    rdData = {16'h0000, ctrl_ff};
      `OCD_IDX_SUPPLY:  rdData = {16'h0000, supply_ff};
      `OCD_IDX_FRAC_UP: rdData = {16'h0000, fracUp_ff};
      `OCD_IDX_FRAC_LO: rdData = {16'h0000, fracLo_ff};
      `OCD_IDX_STATUS:  rdData = {16'h0000, modFalling, pending, actCtrl[15:12],
                                  modPhase};
      default:          decErr = 1'b1;
    endcase
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff   <= ST_IDLE;
      prdata_ff  <= 32'h00000000;
      pslverr_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      if (access && state_ff == ST_IDLE) begin
        prdata_ff  <= pwrite ? 32'h00000000 : rdData;
        pslverr_ff <= decErr;
      end else if (state_ff == ST_ACK) begin
        pslverr_ff <= 1'b0;
      end
    end
  end

  // Register writes
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_ff   <= `OCD_RST_CTRL;
      supply_ff <= `OCD_RST_SUPPLY;
      fracUp_ff <= `OCD_RST_FRAC_UP;
      fracLo_ff <= `OCD_RST_FRAC_LO;
    end else if (wrEn) begin
      case (regIdx)
        `OCD_IDX_CTRL:    ctrl_ff <= pwdata[15:0];
        `OCD_IDX_SUPPLY:  supply_ff <= pwdata[15:0];
        `OCD_IDX_FRAC_UP: fracUp_ff <= pwdata[15:0];
        `OCD_IDX_FRAC_LO: fracLo_ff <= pwdata[15:0];
        default:          ctrl_ff <= ctrl_ff;
      endcase
    end
  end

  // Settings applied through the switch
  assign newCfg = {ctrl_ff, fracUp_ff, fracLo_ff[`OCD_LO_W-1:0]};

  ocd_safe_switch u_switch (
    .core_clk      (core_clk),
    .rst_n         (rst_n),
    .newCfg        (newCfg),
    .safeEn        (ctrl_ff[`OCD_B_SAFE]),
    .boundary      (fall[2]),
    .appliedCfg_ff (appliedCfg),
    .pending       (pending)
  );

  assign actCtrl = appliedCfg[`OCD_CFG_W-1:`OCD_CFG_W-16];
  assign actFrac = appliedCfg[24:0];

  assign spreadTick = actCtrl[`OCD_B_SRC] ? rise[1] : fracClkOut_ff && rise[0];

  ocd_spread_gen u_spread (
    .core_clk       (core_clk),
    .rst_n          (rst_n),
    .srcTick        (spreadTick),
    .enable         (actCtrl[`OCD_B_SPEN]),
    .divide         (actCtrl[`OCD_F_DIV_HI:`OCD_F_DIV_LO]),
    .period         (actCtrl[`OCD_F_PER_HI:`OCD_F_PER_LO]),
    .downProfile    (actCtrl[`OCD_B_PROFILE]),
    .depth          (actCtrl[`OCD_F_DEPTH_HI:`OCD_F_DEPTH_LO]),
    .modPhase_ff    (modPhase),
    .modFalling_ff  (modFalling),
    .peakQuarter_ff (peakQuarter),
    .centreMode_ff  (centreMode)
  );

  // Fraction accumulator
  assign accSum = {1'b0, acc_ff} + {1'b0, actFrac};

  always @* begin
    nxt_acc     = acc_ff;
    nxt_fracOut = fracClkOut_ff;
    if (actCtrl[`OCD_B_FRST]) begin
      nxt_acc     = 25'h0000000;
      nxt_fracOut = 1'b0;
    end else if (actCtrl[`OCD_B_BYPASS]) begin
      nxt_fracOut = pinSync[0];
    end else if (!actCtrl[`OCD_B_DELAY] && rise[0]) begin
      nxt_acc = accSum[24:0];
      if (accSum[25]) begin
        nxt_fracOut = !fracClkOut_ff;
      end
    end
  end

  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      acc_ff                  <= 25'h0000000;
      fracClkOut_ff           <= 1'b0;
      delayWord_ff            <= 25'h0000000;
      ch1_frac_delay_select   <= 1'b0;
      ch1_frac_bypass         <= 1'b0;
      ch1_frac_reset          <= 1'b0;
      ch1_spread_clock_source <= 1'b0;
      ch1_low_supply_flag     <= 1'b1;
      switchPending_ff        <= 1'b0;
    end else begin
      acc_ff        <= nxt_acc;
      fracClkOut_ff <= nxt_fracOut;
      delayWord_ff  <= actCtrl[`OCD_B_DELAY] ? actFrac : 25'h0000000;
      ch1_frac_delay_select   <= actCtrl[`OCD_B_DELAY];
      ch1_frac_bypass         <= actCtrl[`OCD_B_BYPASS];
      ch1_frac_reset          <= actCtrl[`OCD_B_FRST];
      ch1_spread_clock_source <= actCtrl[`OCD_B_SRC];
      ch1_low_supply_flag     <= supply_ff[`OCD_B_LOWSUP];
      switchPending_ff        <= pending;
    end
  end
endmodule // ocd_channel_config

// ---- testbench/ocd_channel_config_chk.sv ----
`timescale 1ns/1ps
module ocd_channel_config_chk (
  input wire        core_clk,
  input wire        rst_n,
  input wire        psel,
  input wire        penable,
  input wire        pready,
  input wire        pslverr_ff,
  input wire        ch1_frac_reset,
  input wire        fracClkOut_ff,
  input wire        ch1_frac_delay_select,
  input wire [24:0] delayWord_ff,
  input wire [9:0]  modPhase,
  input wire [4:0]  peakQuarter,
  input wire        centreMode
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence accWait; psel && penable && !pready; endsequence
  sequence rstHeld; ch1_frac_reset [*2]; endsequence
  chk_one_wait: assert property (accWait |=> pready)
    else $error("ready late");
  chk_ready_req: assert property (pready |-> psel && penable)
    else $error("ready without access");
  chk_err_ready: assert property (pslverr_ff |-> pready)
    else $error("error without ready");
  chk_frac_held: assert property (rstHeld |-> !fracClkOut_ff)
    else $error("divider runs in reset");
  chk_word_mode: assert property (!ch1_frac_delay_select |-> delayWord_ff == 25'h0)
    else $error("delay word outside delay mode");
  chk_period_max: assert property (modPhase <= 10'h22b)
    else $error("phase beyond period");
  chk_phase_step: assert property ($changed(modPhase) |->
    modPhase == $past(modPhase) + 10'h1 || modPhase == 10'h0)
    else $error("phase jump");
  chk_depth_centre: assert property (centreMode |-> peakQuarter inside {0, 1, 2, 4, 10})
    else $error("bad centre depth");
  chk_depth_down: assert property (!centreMode |-> peakQuarter inside {0, 2, 4, 8, 20})
    else $error("bad down depth");
endmodule // ocd_channel_config_chk

// ---- testbench/ocd_channel_config_tb.sv ----
`timescale 1ns/1ps
module ocd_channel_config_tb;
  logic        core_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic        fracClkIn = 0, refClkIn = 0, chanClkIn = 1;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [15:0] v;
  logic [4:0]  dn [4] = '{5'h02, 5'h04, 5'h08, 5'h14};
  logic [32:0] expQ [$];
  int          fails = 0, checks = 0;
  wire         pready, pslverr_ff, fracClkOut_ff, ch1_frac_delay_select, ch1_frac_bypass;
  wire         ch1_frac_reset, ch1_spread_clock_source, ch1_low_supply_flag;
  wire         modFalling, centreMode, switchPending_ff;
  wire [31:0]  prdata_ff;
  wire [24:0]  delayWord_ff;
  wire [9:0]   modPhase;
  wire [4:0]   peakQuarter;
  ocd_channel_config dut (.core_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pready, .prdata_ff, .pslverr_ff, .fracClkIn, .refClkIn, .chanClkIn, .fracClkOut_ff,
    .ch1_frac_delay_select, .ch1_frac_bypass, .ch1_frac_reset, .ch1_spread_clock_source,
    .delayWord_ff, .ch1_low_supply_flag, .modPhase, .modFalling, .peakQuarter,
    .centreMode, .switchPending_ff);
  always #12.5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    refClkIn <= ~refClkIn;
    fracClkIn <= 1'($urandom);
  end
  task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= {16'h0, d};
    @(posedge core_clk);
    penable <= 1;
    do begin @(posedge core_clk); n++; end while (pready !== 1'b1 && n < 20);
    if (n == 20) cmp(33'h0, 33'h1);
    psel <= 0; penable <= 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] e);
    expQ.push_back(e);
    apb(0, a, 16'h0);
  endtask
  task automatic pause(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic summarize;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  always @(posedge core_clk)
    if (psel && penable && pready === 1'b1 && !pwrite) cmp({pslverr_ff, prdata_ff}, expQ.pop_front());
  initial begin
    #200us;
    fails++;
    summarize;
  end
  initial begin
    void'($urandom(32'he7fda310));
    pause(8);
    rst_n <= 1;
    rd(8'h9c, 33'h679);
    rd(8'ha0, 33'h8);
    rd(8'ha4, 33'h8000);
    rd(8'ha8, 33'h0);
    apb(1, 8'h10, 16'hffff);
    rd(8'h10, 33'h100000000);
    cmp(33'({ch1_low_supply_flag, centreMode, peakQuarter}), 33'h62);
    $display("reset values done");
    repeat (3) for (int i = 0; i < 4; i++) begin
      v = 16'($urandom) & (i == 0 ? 16'hbffe : 16'hffff);
      apb(1, 8'h9c + 8'(4 * i), v);
      rd(8'h9c + 8'(4 * i), {17'h0, v});
    end
    $display("read back done");
    apb(1, 8'ha4, 16'h1234);
    apb(1, 8'ha8, 16'hfe5a);
    apb(1, 8'h9c, 16'hd000);
    pause(3);
    cmp(33'({ch1_frac_delay_select, ch1_frac_bypass, ch1_frac_reset,
      ch1_spread_clock_source}), 33'hd);
    cmp(33'(delayWord_ff), {8'h00, 16'h1234, 9'h05a});
    rd(8'hfc, 33'h3400);
    apb(1, 8'h9c, 16'h2000);
    pause(4);
    cmp(33'({ch1_frac_reset, fracClkOut_ff, delayWord_ff}), 33'h4000000);
    $display("divider modes done");
    for (int i = 0; i < 8; i++) begin
      apb(1, 8'h9c, {7'h0, i[2], i[1:0], 6'h08});
      pause(3);
      cmp(33'({centreMode, peakQuarter}), 33'({~i[2],
        i[2] ? dn[i[1:0]] : dn[i[1:0]] >> 1}));
    end
    apb(1, 8'h9c, 16'h0140);
    pause(3);
    cmp(33'(peakQuarter), 33'h0);
    $display("spread table done");
    apb(1, 8'h9c, 16'h1208);
    pause(40);
    cmp(33'(modPhase != 10'h0), 33'h1);
    cmp(33'(modPhase >= 10'h008 && modPhase <= 10'h00b), 33'h1);
    pause(1000);
    cmp(33'(modPhase < 10'h0f0), 33'h1);
    cmp(33'(modFalling), 33'(modPhase >= 10'h078));
    $display("modulation done");
    apb(1, 8'h9c, 16'h0009);
    pause(6);
    cmp(33'({switchPending_ff, ch1_spread_clock_source}), 33'h3);
    chanClkIn <= 0;
    pause(8);
    cmp(33'({switchPending_ff, ch1_spread_clock_source}), 33'h0);
    apb(1, 8'ha0, 16'h0);
    pause(2);
    cmp(33'(ch1_low_supply_flag), 33'h0);
    $display("switching done");
    summarize;
  end
endmodule // ocd_channel_config_tb
bind ocd_channel_config ocd_channel_config_chk chk (.core_clk, .rst_n, .psel, .penable,
  .pready, .pslverr_ff, .ch1_frac_reset, .fracClkOut_ff, .ch1_frac_delay_select,
  .delayWord_ff, .modPhase, .peakQuarter, .centreMode);
